//--- core/fdc_pkg.sv
// Constants, types and register map of the depth-expansion FIFO stage.
package fdc_pkg;

	// ---------------------------------------------------------------
	// Storage geometry and counts
	// ---------------------------------------------------------------
	localparam int DEPTH = 256;
	localparam logic [8:0] DEPTH_CNT = 9'h100;
	localparam logic [8:0] DEPTH_FALL = 9'h101;
	localparam logic [8:0] HALF_CNT = 9'h080;
	localparam logic [7:0] LAST_ADDR = 8'hff;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;
	localparam logic [8:0] AE_OFS_RST = 9'h007;
	localparam logic [8:0] AF_OFS_RST = 9'h007;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [31:0] ADDR_AE_OFS = 32'h0000_0000;
	localparam logic [31:0] ADDR_AF_OFS = 32'h0000_0004;
	localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
	localparam logic [31:0] ADDR_MODE = 32'h0000_000c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {FDC_SEL_NONE, FDC_SEL_AE, FDC_SEL_AF, FDC_SEL_STATUS, FDC_SEL_MODE} fdc_sel_type;
	typedef enum logic [1:0] {FDC_STD, FDC_FALL_THROUGH_MODE, FDC_DAISY} fdc_mode_type;

	typedef struct packed {
		logic [14:0] zero;
		logic half_full;
		logic almost_full;
		logic almost_empty;
		logic full;
		logic empty;
		logic rd_priv;
		logic wr_priv;
		logic out_valid;
		logic [8:0] count;
	} fdc_status_type;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} fdc_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} fdc_axi_rsp_type;

endpackage

//--- core/fdc_fifo_stage.sv
// One 18-bit FIFO stage with daisy-chain and fall-through depth expansion.
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module fdc_fifo_stage (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic chain_head_select,
	input wire logic write_token_in,
	input wire logic read_token_in,
	input wire logic offset_load_select,
	input wire logic wr_en_n,
	input wire logic [17:0] wr_data,
	input wire logic rd_en_n,
	output logic [17:0] rd_data,
	output logic empty_indicator,
	output logic full_indicator,
	output logic almost_empty_flag,
	output logic almost_full_flag,
	output logic half_full_flag,
	output logic write_token_out,
	output logic read_token_out,
	input wire fdc_pkg::fdc_axi_req_type axi_req,
	output var fdc_pkg::fdc_axi_rsp_type axi_rsp
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic ae_of(input logic [8:0] cnt, input logic [8:0] ofs);
		ae_of = !(cnt <= ofs);
	endfunction

	function automatic logic af_of(input logic [8:0] cnt, input logic [8:0] ofs, input logic [8:0] cap);
		af_of = !(cnt >= cap - ofs);
	endfunction

	function automatic fdc_pkg::fdc_sel_type sel_of(input logic [31:0] a);
		if (a == fdc_pkg::ADDR_AE_OFS) sel_of = fdc_pkg::FDC_SEL_AE;
		else if (a == fdc_pkg::ADDR_AF_OFS) sel_of = fdc_pkg::FDC_SEL_AF;
		else if (a == fdc_pkg::ADDR_STATUS) sel_of = fdc_pkg::FDC_SEL_STATUS;
		else if (a == fdc_pkg::ADDR_MODE) sel_of = fdc_pkg::FDC_SEL_MODE;
		else sel_of = fdc_pkg::FDC_SEL_NONE;
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [17:0] mem [fdc_pkg::DEPTH];
	logic [2:0] strap_s1, strap_s2;
	logic [1:0] cfg_cnt, next_cfg_cnt;
	fdc_pkg::fdc_mode_type mode, next_mode;
	logic head, next_head, dbl, next_dbl;
	logic [7:0] wptr, rptr, next_wptr, next_rptr;
	logic [8:0] mcount, next_mcount, tot, next_tot, cap;
	logic out_valid, next_out_valid;
	logic [17:0] next_rd_data;
	logic wr_priv, rd_priv, next_wr_priv, next_rd_priv;
	logic wto, rto, next_wto, next_rto;
	logic ef1, ff1, ef2, ff2, next_ef1, next_ff1;
	logic hf, pae_s, paf_s, next_hf, next_pae_s, next_paf_s;
	logic [8:0] ae_ofs, af_ofs, next_ae_ofs, next_af_ofs;
	logic ofs_sel, next_ofs_sel;
	logic cfg_done, daisy, fall_through_mode, wr_ok, rd_ok, pop;
	logic aw_got, w_got, next_aw_got, next_w_got, aw_take, w_take, axi_we;
	logic [31:0] awaddr, wdata, next_awaddr, next_wdata, wa, wd;
	logic [3:0] wstrb, next_wstrb, ws;
	logic bvalid, rvalid, next_bvalid, next_rvalid, ar_take;
	logic [1:0] bresp, rresp, next_bresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	fdc_pkg::fdc_sel_type wsel;
	fdc_pkg::fdc_status_type status;

	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	always_comb begin
		aw_take = axi_req.awvalid & ~aw_got & ~bvalid;
		w_take = axi_req.wvalid & ~w_got & ~bvalid;
		wa = aw_take ? axi_req.awaddr : awaddr;
		wd = w_take ? axi_req.wdata : wdata;
		ws = w_take ? axi_req.wstrb : wstrb;
		wsel = sel_of(wa);
		axi_we = (aw_got | aw_take) & (w_got | w_take);
		next_aw_got = (aw_got | aw_take) & ~axi_we;
		next_w_got = (w_got | w_take) & ~axi_we;
		next_awaddr = wa;
		next_wdata = wd;
		next_wstrb = ws;
		next_bvalid = axi_we | (bvalid & ~axi_req.bready);
		next_bresp = bresp;
		if (axi_we) begin
			next_bresp = (wsel == fdc_pkg::FDC_SEL_NONE) ? fdc_pkg::RESP_SLVERR : fdc_pkg::RESP_OKAY;
		end
		status = '0;
		status.count = mcount;
		status.out_valid = out_valid;
		status.wr_priv = wr_priv;
		status.rd_priv = rd_priv;
		status.empty = empty_indicator;
		status.full = full_indicator;
		status.almost_empty = almost_empty_flag;
		status.almost_full = almost_full_flag;
		status.half_full = half_full_flag;
		ar_take = axi_req.arvalid & ~rvalid;
		next_rvalid = ar_take | (rvalid & ~axi_req.rready);
		next_rdata = rdata;
		next_rresp = rresp;
		if (ar_take) begin
			next_rresp = fdc_pkg::RESP_OKAY;
			case (sel_of(axi_req.araddr))
				fdc_pkg::FDC_SEL_AE: next_rdata = {23'h000000, ae_ofs};
				fdc_pkg::FDC_SEL_AF: next_rdata = {23'h000000, af_ofs};
				fdc_pkg::FDC_SEL_STATUS: next_rdata = status;
				fdc_pkg::FDC_SEL_MODE: next_rdata = {28'h0000000, dbl, head, mode};
				default: begin
					next_rdata = 32'h0000_0000;
					next_rresp = fdc_pkg::RESP_SLVERR;
				end
			endcase
		end
		axi_rsp.awready = ~aw_got & ~bvalid;
		axi_rsp.wready = ~w_got & ~bvalid;
		axi_rsp.bvalid = bvalid;
		axi_rsp.bresp = bresp;
		axi_rsp.arready = ~rvalid;
		axi_rsp.rvalid = rvalid;
		axi_rsp.rdata = rdata;
		axi_rsp.rresp = rresp;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awaddr <= 32'h0000_0000;
			wdata <= 32'h0000_0000;
			wstrb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= fdc_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= fdc_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			awaddr <= next_awaddr;
			wdata <= next_wdata;
			wstrb <= next_wstrb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Storage, flags and tokens
	// ---------------------------------------------------------------
	// Straps settle through two flops before capture, so the mode is fixed a few edges after release.
	always_comb begin
		cfg_done = cfg_cnt == fdc_pkg::STRAP_SETTLE;
		daisy = mode == fdc_pkg::FDC_DAISY;
		fall_through_mode = mode == fdc_pkg::FDC_FALL_THROUGH_MODE;
		next_cfg_cnt = cfg_done ? cfg_cnt : cfg_cnt + 2'h1;
		next_mode = mode;
		next_head = head;
		next_dbl = dbl;
		next_wr_priv = wr_priv;
		next_rd_priv = rd_priv;
		if (!cfg_done && next_cfg_cnt == fdc_pkg::STRAP_SETTLE) begin
			if (strap_s2[1] & strap_s2[0]) next_mode = fdc_pkg::FDC_DAISY;
			else if (strap_s2[0]) next_mode = fdc_pkg::FDC_FALL_THROUGH_MODE;
			else next_mode = fdc_pkg::FDC_STD;
			next_head = ~strap_s2[2];
			next_dbl = strap_s2[1] & ~strap_s2[0];
			next_wr_priv = strap_s2[1] & strap_s2[0] & ~strap_s2[2];
			next_rd_priv = strap_s2[1] & strap_s2[0] & ~strap_s2[2];
		end
		cap = fall_through_mode ? fdc_pkg::DEPTH_FALL : fdc_pkg::DEPTH_CNT;
		wr_ok = cfg_done & ~wr_en_n & offset_load_select & (mcount != fdc_pkg::DEPTH_CNT) & (~daisy | wr_priv);
		pop = fall_through_mode & ~rd_en_n & out_valid;
		// A fall-through stage refills its output register on its own, with no read request.
		rd_ok = cfg_done & (mcount != 9'h000) & (fall_through_mode ? (~out_valid | pop) : (~rd_en_n & (~daisy | rd_priv)));
		next_wptr = wptr + 8'(wr_ok);
		next_rptr = rptr + 8'(rd_ok);
		next_mcount = mcount + 9'(wr_ok) - 9'(rd_ok);
		next_out_valid = fall_through_mode & (rd_ok | (out_valid & ~pop));
		next_rd_data = rd_ok ? mem[rptr] : rd_data;
		tot = mcount + 9'(out_valid);
		next_tot = next_mcount + 9'(next_out_valid);
		next_ef1 = fall_through_mode ? ~next_out_valid : (next_mcount != 9'h000);
		next_ff1 = fall_through_mode ? (next_mcount == fdc_pkg::DEPTH_CNT) : (next_mcount != fdc_pkg::DEPTH_CNT);
		next_hf = daisy | ~(next_tot > fdc_pkg::HALF_CNT);
		next_pae_s = ae_of(next_tot, ae_ofs);
		next_paf_s = af_of(next_tot, af_ofs, cap);
		next_wto = 1'b1;
		next_rto = 1'b1;
		if (daisy && wr_ok && wptr == fdc_pkg::LAST_ADDR) begin
			next_wr_priv = 1'b0;
			next_wto = 1'b0;
		end
		if (daisy && rd_ok && rptr == fdc_pkg::LAST_ADDR) begin
			next_rd_priv = 1'b0;
			next_rto = 1'b0;
		end
		if (daisy && !write_token_in) next_wr_priv = 1'b1;
		if (daisy && !read_token_in) next_rd_priv = 1'b1;
		next_ae_ofs = ae_ofs;
		next_af_ofs = af_ofs;
		next_ofs_sel = ofs_sel;
		if (cfg_done && !wr_en_n && !offset_load_select) begin
			next_ofs_sel = ~ofs_sel;
			if (ofs_sel) next_af_ofs = wr_data[8:0];
			else next_ae_ofs = wr_data[8:0];
		end
		if (axi_we && wsel == fdc_pkg::FDC_SEL_AE) begin
			next_ae_ofs = {ws[1] ? wd[8] : ae_ofs[8], ws[0] ? wd[7:0] : ae_ofs[7:0]};
		end
		if (axi_we && wsel == fdc_pkg::FDC_SEL_AF) begin
			next_af_ofs = {ws[1] ? wd[8] : af_ofs[8], ws[0] ? wd[7:0] : af_ofs[7:0]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (wr_ok) mem[wptr] <= wr_data;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			strap_s1 <= 3'h0;
			strap_s2 <= 3'h0;
			cfg_cnt <= 2'h0;
			mode <= fdc_pkg::FDC_STD;
			head <= 1'b0;
			dbl <= 1'b0;
			wptr <= 8'h00;
			rptr <= 8'h00;
			mcount <= 9'h000;
			out_valid <= 1'b0;
			rd_data <= 18'h00000;
			wr_priv <= 1'b0;
			rd_priv <= 1'b0;
			wto <= 1'b1;
			rto <= 1'b1;
			ef1 <= 1'b0;
			ff1 <= 1'b1;
			ef2 <= 1'b0;
			ff2 <= 1'b1;
			hf <= 1'b1;
			pae_s <= 1'b0;
			paf_s <= 1'b1;
			ae_ofs <= fdc_pkg::AE_OFS_RST;
			af_ofs <= fdc_pkg::AF_OFS_RST;
			ofs_sel <= 1'b0;
		end else begin
			strap_s1 <= {chain_head_select, read_token_in, write_token_in};
			strap_s2 <= strap_s1;
			cfg_cnt <= next_cfg_cnt;
			mode <= next_mode;
			head <= next_head;
			dbl <= next_dbl;
			wptr <= next_wptr;
			rptr <= next_rptr;
			mcount <= next_mcount;
			out_valid <= next_out_valid;
			rd_data <= next_rd_data;
			wr_priv <= next_wr_priv;
			rd_priv <= next_rd_priv;
			wto <= next_wto;
			rto <= next_rto;
			ef1 <= next_ef1;
			ff1 <= next_ff1;
			ef2 <= ef1;
			ff2 <= ff1;
			hf <= next_hf;
			pae_s <= next_pae_s;
			paf_s <= next_paf_s;
			ae_ofs <= next_ae_ofs;
			af_ofs <= next_af_ofs;
			ofs_sel <= next_ofs_sel;
		end
	end

	// Daisy-chain almost flags follow the count directly; they may glitch between edges.
	always_comb begin
		empty_indicator = dbl ? ef2 : ef1;
		full_indicator = dbl ? ff2 : ff1;
		almost_empty_flag = daisy ? ae_of(tot, ae_ofs) : pae_s;
		almost_full_flag = daisy ? af_of(tot, af_ofs, cap) : paf_s;
		half_full_flag = hf;
		write_token_out = wto;
		read_token_out = rto;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence tok_pulse_s(sig);
		!sig ##1 sig;
	endsequence

	hf_daisy_idle_a: assert property (daisy |-> half_full_flag) else $error("half-full active in daisy chain");
	flag_single_a: assert property (daisy && wr_ok && mcount == 9'h000 |=> empty_indicator) else $error("empty flag late");
	ae_async_a: assert property (daisy && $changed(tot) |-> almost_empty_flag == !(tot <= ae_ofs)) else $error("ae not async");
	first_fall_a: assert property (fall_through_mode && wr_ok && tot == 9'h000 |-> ##[1:3] !empty_indicator) else $error("no fall-through");
	or_valid_a: assert property (fall_through_mode && rd_ok |=> !empty_indicator && rd_data == $past(mem[rptr])) else $error("or wrong");
	no_extra_a: assert property (fall_through_mode && pop && mcount != 9'h000 |=> !empty_indicator) else $error("gap in output");
	ir_free_a: assert property (fall_through_mode && mcount == fdc_pkg::DEPTH_CNT && rd_ok |=> !full_indicator) else $error("ir late");
	depth_sum_a: assert property (fall_through_mode && tot == fdc_pkg::DEPTH_FALL |-> full_indicator) else $error("depth sum");
	wtok_pass_a: assert property (daisy && wr_ok && wptr == fdc_pkg::LAST_ADDR |=> tok_pulse_s(write_token_out)) else $error("wtok");
	rtok_pass_a: assert property (daisy && rd_ok && rptr == fdc_pkg::LAST_ADDR |=> tok_pulse_s(read_token_out)) else $error("rtok");
	strap_mode_a: assert property ($rose(cfg_done) |-> daisy == ($past(strap_s2[1]) && $past(strap_s2[0]))) else $error("mode");

endmodule
`default_nettype wire

//--- sim/fdc_reader.sv
// Downstream reader model that pops words from a fall-through stage.
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// Reader
// ---------------------------------------------------------------
module fdc_reader (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic go,
	input wire logic out_ready_n,
	input wire logic [17:0] word,
	output logic rd_en_n
);
	logic [17:0] got[$];
	// Read and transfer clock are the one free-running clock, so it never pauses.
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_en_n <= 1'b1;
			got.delete();
		end else begin
			if (!rd_en_n && !out_ready_n) begin
				got.push_back(word);
			end
			rd_en_n <= !(go && !out_ready_n);
		end
	end
endmodule
`default_nettype wire

//--- sim/fifo_depth_cascade_bench.sv
// Self-checking bench for the depth-expansion FIFO stage.
`timescale 1ns/1ns
`default_nettype none
module fifo_depth_cascade_bench;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic chain_head_select = 1'b0;
	logic write_token_in = 1'b0;
	logic read_token_in = 1'b0;
	logic offset_load_select = 1'b1;
	logic wr_en_n = 1'b1;
	logic [17:0] wr_data = 18'h00000;
	logic go = 1'b0;
	logic rd_en_n;
	logic [17:0] rd_data;
	logic empty_indicator, full_indicator, almost_empty_flag, almost_full_flag, half_full_flag;
	logic write_token_out, read_token_out;
	fdc_pkg::fdc_axi_req_type axi_req = '{bready: 1'b1, rready: 1'b1, default: '0};
	fdc_pkg::fdc_axi_rsp_type axi_rsp;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	logic [31:0] rd;
	logic [1:0] resp;

	always #5 ref_clk = ~ref_clk;

	fdc_fifo_stage dut (.ref_clk(ref_clk), .resetn(resetn), .chain_head_select(chain_head_select),
		.write_token_in(write_token_in), .read_token_in(read_token_in), .offset_load_select(offset_load_select),
		.wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n), .rd_data(rd_data),
		.empty_indicator(empty_indicator), .full_indicator(full_indicator), .almost_empty_flag(almost_empty_flag),
		.almost_full_flag(almost_full_flag), .half_full_flag(half_full_flag), .write_token_out(write_token_out),
		.read_token_out(read_token_out), .axi_req(axi_req), .axi_rsp(axi_rsp));
	fdc_reader partner (.ref_clk(ref_clk), .resetn(resetn), .go(go), .out_ready_n(empty_indicator),
		.word(rd_data), .rd_en_n(rd_en_n));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// The whole run is about seven hundred cycles, so this limit only trips on a hang.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	task automatic do_reset(input logic h, input logic r, input logic w);
		@(posedge ref_clk);
		resetn <= 1'b0;
		chain_head_select <= h;
		read_token_in <= r;
		write_token_in <= w;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask

	task automatic fill(input logic [17:0] base, input int cnt);
		@(posedge ref_clk);
		for (int i = 0; i < cnt; i++) begin
			wr_en_n <= 1'b0;
			wr_data <= base + 18'(i);
			@(posedge ref_clk);
		end
		wr_en_n <= 1'b1;
		#1;
	endtask

	task automatic axi_write(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] rsp);
		logic aw_go, w_go, b_seen;
		@(posedge ref_clk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= addr;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= data;
		axi_req.wstrb <= 4'hf;
		b_seen = 1'b0;
		while (!b_seen) begin
			#1;
			aw_go = axi_req.awvalid && axi_rsp.awready;
			w_go = axi_req.wvalid && axi_rsp.wready;
			b_seen = axi_rsp.bvalid;
			rsp = axi_rsp.bresp;
			@(posedge ref_clk);
			if (aw_go) axi_req.awvalid <= 1'b0;
			if (w_go) axi_req.wvalid <= 1'b0;
		end
		#1;
	endtask

	task automatic axi_read(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] rsp);
		logic ar_go, r_seen;
		@(posedge ref_clk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= addr;
		r_seen = 1'b0;
		while (!r_seen) begin
			#1;
			ar_go = axi_req.arvalid && axi_rsp.arready;
			r_seen = axi_rsp.rvalid;
			data = axi_rsp.rdata;
			rsp = axi_rsp.rresp;
			@(posedge ref_clk);
			if (ar_go) axi_req.arvalid <= 1'b0;
		end
		#1;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_registers();
		do_reset(1'b0, 1'b0, 1'b0);
		check({empty_indicator, full_indicator, half_full_flag, write_token_out, read_token_out}, 32'h0f);
		axi_read(fdc_pkg::ADDR_MODE, rd, resp);
		check(rd, 32'h0000_0004);
		axi_read(fdc_pkg::ADDR_AE_OFS, rd, resp);
		check(rd, 32'h0000_0007);
		axi_write(fdc_pkg::ADDR_AF_OFS, 32'h0000_0155, resp);
		check(resp, fdc_pkg::RESP_OKAY);
		axi_read(fdc_pkg::ADDR_AF_OFS, rd, resp);
		check(rd, 32'h0000_0155);
		axi_write(32'h0000_0010, 32'h0000_0001, resp);
		check(resp, fdc_pkg::RESP_SLVERR);
		axi_read(32'h0000_0010, rd, resp);
		check(rd, 32'h0000_0000);
		check(32'(resp), 32'(fdc_pkg::RESP_SLVERR));
	endtask

	task automatic t_standalone();
		do_reset(1'b1, 1'b1, 1'b0);
		axi_read(fdc_pkg::ADDR_MODE, rd, resp);
		check(rd, 32'h0000_0008);
	endtask

	task automatic t_daisy();
		do_reset(1'b0, 1'b1, 1'b1);
		axi_read(fdc_pkg::ADDR_MODE, rd, resp);
		check(rd, 32'h0000_0006);
		fill(18'h00100, 8);
		check({empty_indicator, almost_empty_flag}, 32'h3);
		fill(18'h00200, 248);
		n = 0;
		repeat (4) begin
			if (!write_token_out) n++;
			step();
		end
		check(n, 1);
		check({full_indicator, half_full_flag, almost_full_flag, read_token_out}, 32'h5);
	endtask

	task automatic t_follower();
		do_reset(1'b1, 1'b1, 1'b1);
		axi_read(fdc_pkg::ADDR_MODE, rd, resp);
		check(rd, 32'h0000_0002);
		@(posedge ref_clk);
		offset_load_select <= 1'b0;
		fill(18'h00003, 2);
		@(posedge ref_clk);
		offset_load_select <= 1'b1;
		axi_read(fdc_pkg::ADDR_AE_OFS, rd, resp);
		check(rd, 32'h0000_0003);
		axi_read(fdc_pkg::ADDR_AF_OFS, rd, resp);
		check(rd, 32'h0000_0004);
		fill(18'h00011, 1);
		check(32'(empty_indicator), 32'h0);
		@(posedge ref_clk);
		write_token_in <= 1'b0;
		read_token_in <= 1'b0;
		@(posedge ref_clk);
		write_token_in <= 1'b1;
		read_token_in <= 1'b1;
		fill(18'h00022, 1);
		check(32'({empty_indicator, almost_empty_flag}), 32'h2);
		axi_read(fdc_pkg::ADDR_STATUS, rd, resp);
		check(rd, 32'h0001_bc01);
	endtask

	task automatic t_fall();
		do_reset(1'b1, 1'b0, 1'b1);
		axi_read(fdc_pkg::ADDR_MODE, rd, resp);
		check(rd, 32'h0000_0001);
		fill(18'h2a5a5, 1);
		n = 0;
		while (empty_indicator && n < 10) begin
			n++;
			step();
		end
		check(n <= 3, 1);
		check({empty_indicator, rd_data}, {1'b0, 18'h2a5a5});
		@(posedge ref_clk);
		go <= 1'b1;
		fill(18'h30000, 20);
		n = 0;
		while (partner.got.size() < 21 && n < 40) begin
			n++;
			step();
		end
		check(n <= 4, 1);
		for (int i = 0; i < 21; i++) begin
			check(partner.got[i], (i == 0) ? 18'h2a5a5 : 18'h30000 + 18'(i - 1));
		end
		@(posedge ref_clk);
		go <= 1'b0;
	endtask

	task automatic t_bubble();
		do_reset(1'b1, 1'b0, 1'b1);
		fill(18'h01000, 257);
		check({empty_indicator, full_indicator, almost_full_flag, half_full_flag}, 32'h4);
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		#1;
		n = 0;
		while (full_indicator && n < 10) begin
			n++;
			step();
		end
		check(n <= 4, 1);
		check(32'(full_indicator), 32'h0);
		check(partner.got.size(), 32'd1);
		check(32'(partner.got[0]), 32'h0000_1000);
	endtask

	initial begin
		t_registers();
		t_standalone();
		t_daisy();
		t_follower();
		t_fall();
		t_bubble();
		give_verdict();
	end
endmodule
`default_nettype wire
